// ==== emb_defines.svh ====
// Offsets, field positions, reset values and timing counts of the external bus controller.
// Assumes inclusion by emb_ctrl.sv by bare name; emb_pkg.sv does not include it.
`ifndef EMB_DEFINES_SVH
`define EMB_DEFINES_SVH
// -----------------------------------------------------------------------------
// Register map (byte addresses on the APB)
// -----------------------------------------------------------------------------
`define EMB_OFS_BUS_CTL 12'h000
`define EMB_OFS_PORT_G 12'h004
`define EMB_OFS_CFG 12'h008
`define EMB_OFS_STATUS 12'h00c
// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define EMB_CTL_DIS_BIT 7
`define EMB_CTL_WAIT_HI 5
`define EMB_CTL_WAIT_LO 4
`define EMB_CTL_WM_HI 1
`define EMB_CTL_WM_LO 0
`define EMB_PG_PU_D 7
`define EMB_PG_PU_E 6
`define EMB_PG_PU_J 5
`define EMB_CFG_SHIFT 0
`define EMB_CFG_WAIT_EN 1
`define EMB_CFG_BW16 2
`define EMB_CFG_WID_HI 4
`define EMB_CFG_WID_LO 3
// -----------------------------------------------------------------------------
// Reset values and fixed figures
// -----------------------------------------------------------------------------
`define EMB_CTL_RST 8'h00
`define EMB_PG_RST 8'he0
`define EMB_CFG_RST 8'h04
`define EMB_CTL_MASK 8'hb3
`define EMB_ONCHIP_SIZE 21'h020000
`define EMB_WAIT_MAX 2'h3
`define EMB_SYNC_WAIT 2'h2
`define EMB_CLK_NS 25
`endif

// ==== emb_pkg.sv ====
// Types shared by the external bus controller.
// Assumes nothing from emb_defines.svh; it uses no macros and does not include it.
package emb_pkg;
	typedef enum logic [1:0] {
		EMB_MCU_ONLY = 2'b00,
		EMB_ADDR12 = 2'b01,
		EMB_ADDR16 = 2'b10,
		EMB_ADDR20 = 2'b11
	} emb_width_type;

	typedef enum logic [2:0] {
		EMB_IDLE = 3'b000,
		EMB_ADR = 3'b001,
		EMB_ACC = 3'b010,
		EMB_WAIT = 3'b011,
		EMB_DONE = 3'b100
	} emb_state_type;

	typedef struct packed {
		logic fetch;
		logic tbl_rd;
		logic tbl_wr;
		logic [20:0] table_pointer;
		logic [7:0] table_latch;
		logic external;
	} emb_req_type;

	typedef struct packed {
		logic [15:0] ad_out;
		logic [15:0] ad_oe;
		logic [3:0] a_hi;
		logic [3:0] a_hi_oe;
		logic ale;
		logic oe_n;
		logic ce_n;
		logic write_high_n;
		logic write_low_n;
		logic upper_byte_sel_n;
		logic lower_byte_sel_n;
		logic byte_addr_line;
	} emb_pins_type;

	typedef struct packed {
		logic [7:0] prdata;
		logic pready;
		logic pslverr;
		logic [7:0] bus_control_reg;
		logic [7:0] port_g_reg;
		logic [7:0] cfg;
		emb_state_type st;
		logic [1:0] wait_cnt;
		logic dis_pending;
		logic pins_bus;
		emb_req_type req;
		emb_pins_type pins;
		logic busy;
		logic [15:0] rd_word;
		logic done;
	} emb_state_all_type;
endpackage

// ==== emb_ctrl.sv ====
// External multiplexed memory bus controller: register file on APB, pin sequencing.
// Assumes a core that issues one fetch or table request at a time and waits for done.
//
// Overview of operation
// R1: Without shifting, bus address equals the program counter unchanged.
// R2: Shift set: subtract on-chip size so first external word is 0000h.
// R3: 20-bit width drives byte address line as address LSB, 2 Mbyte reach.
// R4: Upper and lower byte select outputs are provided.
// R5: 8-bit data muxes only AD7..0; 16-bit data muxes all sixteen lines.
// R6: Wait enable stretches each table access by the wait field after execution.
// R7: Wait field 11 gives 0, 10 one, 01 two, 00 three cycles.
// R8: Three cleared port-level bits enable pull-ups; upper address lines have none.
// R9: Every reset disables all bus-pin pull-ups.
// R10: Internal-only mode keeps pins as ports and ignores control writes.
// R11: Extended mode gives pins bus function on every external access.
// R12: Internal execution: disable bit 0 means bus, 1 means ports; access overrides.
// R13: Disable set from external code waits for a branch into internal memory.
// R14: Idle bus: AD tri-stated, strobes and selects high, latch enable and byte line low.
// R15: Only pins of the configured address width are tri-stated; others stay I/O.
// R16: Bus function has priority over any peripheral sharing the pins.
// R17: 16-bit data selects byte write, word write or byte select by field.
// R18: Write field 1x word write, 01 byte select, 00 byte write.
// R19: 16-bit modes pulse latch enable with address, then output enable both bytes.
// R20: Chip enable low on every external access, high throughout sleep.
// R21: Flash uses byte line and port select; SRAM uses byte selects.
// R22: Byte write drives the table latch on both bus halves.
// R23: Byte write strobes high or low write line from table pointer LSB.
// R24: Pointer LSB 1 strobes the high write line, 0 the low one.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`include "emb_defines.svh"
module emb_ctrl (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire emb_pkg::emb_req_type core_req,
	input wire logic [20:0] program_counter,
	input wire logic sleep_req,
	input wire logic [15:0] ad_in,
	output emb_pkg::emb_pins_type bus_pins,
	output logic [15:0] read_word,
	output logic core_done,
	output logic core_busy,
	output logic pins_are_bus,
	output logic pullup_ctl_port_d,
	output logic pullup_ctl_port_e,
	output logic pullup_ctl_port_j
);
	import emb_pkg::*;

	// -------------------------------------------------------------------------
	// State, pin synchronisers
	// -------------------------------------------------------------------------
	emb_state_all_type s_ff;
	emb_state_all_type nxt_s;
	logic [15:0] ad_meta_ff;
	logic [15:0] ad_sync_ff;
	logic sleep_meta_ff;
	logic sleep_sync_ff;

	// Bus pins come from outside the clock domain, so two flops before use.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ad_meta_ff <= 16'h0000;
			ad_sync_ff <= 16'h0000;
			sleep_meta_ff <= 1'b0;
			sleep_sync_ff <= 1'b0;
		end else begin
			ad_meta_ff <= ad_in;
			ad_sync_ff <= ad_meta_ff;
			sleep_meta_ff <= sleep_req;
			sleep_sync_ff <= sleep_meta_ff;
		end
	end

	// -------------------------------------------------------------------------
	// Derived configuration
	// -------------------------------------------------------------------------
	emb_width_type width;
	logic mcu_only;
	logic bw16;
	logic [1:0] wm;
	logic [1:0] wait_cycles;
	logic [20:0] bus_addr;
	logic [15:0] idle_oe;
	logic [3:0] idle_hi_oe;
	logic apb_acc;
	emb_pins_type idle_pins;

	always_comb begin
		width = emb_width_type'(s_ff.cfg[`EMB_CFG_WID_HI:`EMB_CFG_WID_LO]);
		mcu_only = (width == EMB_MCU_ONLY);
		bw16 = s_ff.cfg[`EMB_CFG_BW16];
		wm = s_ff.bus_control_reg[`EMB_CTL_WM_HI:`EMB_CTL_WM_LO];
		// Field counts down: 11 is none, 00 is the full three cycles.
		wait_cycles = `EMB_WAIT_MAX - s_ff.bus_control_reg[`EMB_CTL_WAIT_HI:`EMB_CTL_WAIT_LO]; // [R7]
		if (!s_ff.cfg[`EMB_CFG_WAIT_EN]) begin
			wait_cycles = 2'h0;
		end
		if (s_ff.cfg[`EMB_CFG_SHIFT]) begin
			bus_addr = program_counter - `EMB_ONCHIP_SIZE; // [R2]
		end else begin
			bus_addr = program_counter; // [R1]
		end
		// Only lines of the configured width are owned by the bus.
		case (width)
			EMB_ADDR12: begin
				idle_oe = 16'h0fff; // [R15]
				idle_hi_oe = 4'h0;
			end
			EMB_ADDR16: begin
				idle_oe = 16'hffff;
				idle_hi_oe = 4'h0; // [R15]
			end
			EMB_ADDR20: begin
				idle_oe = 16'hffff;
				idle_hi_oe = 4'hf;
			end
			default: begin
				idle_oe = 16'h0000;
				idle_hi_oe = 4'h0;
			end
		endcase
		// Idle levels: every strobe high, latch and byte line low, AD released.
		idle_pins = '0; // [R14]
		idle_pins.oe_n = 1'b1;
		idle_pins.ce_n = 1'b1;
		idle_pins.write_high_n = 1'b1;
		idle_pins.write_low_n = 1'b1;
		idle_pins.upper_byte_sel_n = 1'b1;
		idle_pins.lower_byte_sel_n = 1'b1;
		apb_acc = psel && penable && !s_ff.pready;
	end

	// -------------------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------------------
	always_comb begin
		nxt_s = s_ff;
		nxt_s.pready = 1'b0;
		nxt_s.pslverr = 1'b0;
		nxt_s.done = 1'b0;

		// APB slave: one wait cycle, then pready with data; unmapped reads zero.
		if (apb_acc) begin
			nxt_s.pready = 1'b1;
			nxt_s.prdata = 8'h00;
			case (paddr)
				`EMB_OFS_BUS_CTL: begin
					nxt_s.prdata = s_ff.bus_control_reg;
					if (pwrite && !mcu_only) begin
						nxt_s.bus_control_reg = pwdata[7:0] & `EMB_CTL_MASK;
					end // [R10]
				end
				`EMB_OFS_PORT_G: begin
					nxt_s.prdata = s_ff.port_g_reg;
					if (pwrite) begin
						nxt_s.port_g_reg = pwdata[7:0]; // [R8]
					end
				end
				`EMB_OFS_CFG: begin
					nxt_s.prdata = s_ff.cfg;
					if (pwrite) begin
						nxt_s.cfg = pwdata[7:0];
					end
				end
				`EMB_OFS_STATUS: begin
					nxt_s.prdata = {5'h00, s_ff.dis_pending, s_ff.busy, s_ff.pins_bus};
				end
				default: begin
					nxt_s.pslverr = 1'b1;
				end
			endcase
		end

		// Pin ownership from the mode, the disable bit and any running external access.
		if (mcu_only) begin
			nxt_s.pins_bus = 1'b0; // [R10]
			nxt_s.dis_pending = 1'b0;
		end else if (!s_ff.bus_control_reg[`EMB_CTL_DIS_BIT]) begin
			nxt_s.pins_bus = 1'b1; // [R12]
			nxt_s.dis_pending = 1'b0;
		end else if (s_ff.req.external && s_ff.busy) begin
			nxt_s.pins_bus = 1'b1; // [R11]
			nxt_s.dis_pending = 1'b1;
		end else if (s_ff.dis_pending && !(core_req.fetch && !core_req.external)) begin
			nxt_s.pins_bus = 1'b1; // [R13]
		end else begin
			nxt_s.pins_bus = 1'b0; // [R12]
			nxt_s.dis_pending = 1'b0;
		end

		case (s_ff.st)
			EMB_IDLE: begin
				nxt_s.pins = idle_pins;
				nxt_s.pins.ad_oe = 16'h0000; // [R14]
				nxt_s.pins.a_hi_oe = 4'h0;
				nxt_s.busy = 1'b0;
				// The done cycle refuses requests, since the core only drops its level then.
				if ((core_req.fetch || core_req.tbl_rd || core_req.tbl_wr) && !sleep_sync_ff
					&& !s_ff.done) begin
					nxt_s.req = core_req;
					nxt_s.busy = 1'b1;
					if (core_req.external && !mcu_only) begin
						nxt_s.pins_bus = 1'b1; // [R11]
						nxt_s.st = EMB_ADR;
						nxt_s.pins.ce_n = 1'b0; // [R20]
						nxt_s.pins.ale = 1'b1; // [R19]
						nxt_s.pins.ad_out = bus_addr[16:1];
						nxt_s.pins.a_hi = bus_addr[20:17];
						// Byte line is the LSB in wide address, making 21 bits.
						nxt_s.pins.byte_addr_line = (width == EMB_ADDR20) & bus_addr[0]; // [R3]
						// Bus owns its pins outright over any sharing peripheral.
						nxt_s.pins.ad_oe = idle_oe; // [R16]
						nxt_s.pins.a_hi_oe = idle_hi_oe; // [R15]
					end else begin
						nxt_s.st = EMB_DONE;
					end
				end
			end
			EMB_ADR: begin
				nxt_s.pins.ale = 1'b0;
				nxt_s.st = EMB_ACC;
				nxt_s.wait_cnt = `EMB_SYNC_WAIT;
				if (s_ff.req.tbl_wr) begin
					// Byte-wide data is copied onto both halves in 16-bit mode; 8-bit keeps the address byte on AD15..8.
					nxt_s.pins.ad_out = {s_ff.req.table_latch, s_ff.req.table_latch}; // [R22]
					if (!bw16) begin
						nxt_s.pins.ad_out[15:8] = s_ff.pins.ad_out[15:8]; // [R5]
						nxt_s.pins.write_low_n = 1'b0;
					end else if (wm == 2'b00) begin
						// Pointer LSB picks the strobe.
						nxt_s.pins.write_high_n = !s_ff.req.table_pointer[0]; // [R23] [R24]
						nxt_s.pins.write_low_n = s_ff.req.table_pointer[0]; // [R24]
					end else if (wm == 2'b01) begin
						nxt_s.pins.write_high_n = 1'b0; // [R18]
						nxt_s.pins.upper_byte_sel_n = !s_ff.req.table_pointer[0]; // [R4]
						nxt_s.pins.lower_byte_sel_n = s_ff.req.table_pointer[0];
						nxt_s.pins.byte_addr_line = s_ff.req.table_pointer[0]; // [R17]
					end else begin
						nxt_s.pins.write_high_n = 1'b0; // [R18]
						nxt_s.pins.upper_byte_sel_n = 1'b0;
						nxt_s.pins.lower_byte_sel_n = 1'b0;
					end
				end else begin
					// Reads release the data lines; 16-bit enables both bytes at once, 8-bit only the lower.
					nxt_s.pins.ad_oe = bw16 ? 16'h0000 : (idle_oe & 16'hff00); // [R5]
					nxt_s.pins.oe_n = 1'b0; // [R19]
					nxt_s.pins.upper_byte_sel_n = !bw16;
					nxt_s.pins.lower_byte_sel_n = 1'b0;
				end
			end
			EMB_ACC: begin
				// Read data needs two extra cycles to cross the pin synchroniser.
				if (s_ff.wait_cnt != 2'h0) begin
					nxt_s.wait_cnt = s_ff.wait_cnt - 2'h1;
				end else begin
					nxt_s.rd_word = bw16 ? ad_sync_ff : {8'h00, ad_sync_ff[7:0]};
					if ((s_ff.req.tbl_rd || s_ff.req.tbl_wr) && wait_cycles != 2'h0) begin
						nxt_s.wait_cnt = wait_cycles; // [R6]
						nxt_s.st = EMB_WAIT;
					end else begin
						nxt_s.st = EMB_DONE;
					end
				end
			end
			EMB_WAIT: begin
				nxt_s.wait_cnt = s_ff.wait_cnt - 2'h1;
				if (s_ff.wait_cnt == 2'h1) begin
					nxt_s.st = EMB_DONE; // [R6]
				end
			end
			EMB_DONE: begin
				nxt_s.pins = idle_pins;
				nxt_s.pins.ad_oe = 16'h0000; // [R14]
				nxt_s.pins.a_hi_oe = 4'h0;
				nxt_s.done = 1'b1;
				nxt_s.busy = 1'b0;
				nxt_s.st = EMB_IDLE;
			end
			default: begin
				nxt_s.st = EMB_IDLE;
			end
		endcase

		// Sleep forces chip enable and byte selects high.
		if (sleep_sync_ff) begin
			nxt_s.pins.ce_n = 1'b1; // [R20]
			nxt_s.pins.upper_byte_sel_n = 1'b1;
			nxt_s.pins.lower_byte_sel_n = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_ff <= '0;
			s_ff.bus_control_reg <= `EMB_CTL_RST;
			s_ff.port_g_reg <= `EMB_PG_RST; // [R9]
			s_ff.cfg <= `EMB_CFG_RST;
			s_ff.pins.oe_n <= 1'b1;
			s_ff.pins.ce_n <= 1'b1;
			s_ff.pins.write_high_n <= 1'b1;
			s_ff.pins.write_low_n <= 1'b1;
			s_ff.pins.upper_byte_sel_n <= 1'b1;
			s_ff.pins.lower_byte_sel_n <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// -------------------------------------------------------------------------
	// Outputs, all straight from flops
	// -------------------------------------------------------------------------
	assign prdata = {24'h000000, s_ff.prdata};
	assign pready = s_ff.pready;
	assign pslverr = s_ff.pslverr;
	assign bus_pins = s_ff.pins;
	assign read_word = s_ff.rd_word;
	assign core_done = s_ff.done;
	assign core_busy = s_ff.busy;
	assign pins_are_bus = s_ff.pins_bus;
	// A cleared bit enables pull-ups; A19..16 have none at all.
	assign pullup_ctl_port_d = s_ff.port_g_reg[`EMB_PG_PU_D]; // [R8]
	assign pullup_ctl_port_e = s_ff.port_g_reg[`EMB_PG_PU_E];
	assign pullup_ctl_port_j = s_ff.port_g_reg[`EMB_PG_PU_J];

	// -------------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------------
	sequence seq_addr_phase;
		s_ff.st == EMB_ADR && s_ff.pins.ale && !s_ff.pins.ce_n;
	endsequence
	sequence seq_read_phase;
		s_ff.st == EMB_ACC && !s_ff.pins.oe_n;
	endsequence

	AST_ALE_THEN_OE: assert property (@(posedge clk) disable iff (!rst_b) // [R19]
		(seq_addr_phase and !s_ff.req.tbl_wr) |=> seq_read_phase)
		else $error("output enable did not follow the address latch");
	AST_PULLUP_RESET: assert property (@(posedge clk) // [R9]
		!rst_b |=> (pullup_ctl_port_d && pullup_ctl_port_e && pullup_ctl_port_j))
		else $error("pull-ups enabled after reset");
	AST_WAIT_LEN: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
		(s_ff.st == EMB_WAIT && s_ff.wait_cnt == 2'h3) |=> s_ff.st == EMB_WAIT ##1
		s_ff.st == EMB_WAIT ##1 s_ff.st == EMB_DONE)
		else $error("wait stretch length wrong");
	AST_WAIT_ZERO: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
		(s_ff.st == EMB_ACC && s_ff.wait_cnt == 2'h0 && wait_cycles == 2'h0)
		|=> s_ff.st == EMB_DONE)
		else $error("zero wait field still stretched");
	AST_NARROW_WIDTH: assert property (@(posedge clk) disable iff (!rst_b) // [R3] [R15]
		(s_ff.st == EMB_ADR && width != EMB_ADDR20)
		|-> (!s_ff.pins.byte_addr_line && s_ff.pins.a_hi_oe == 4'h0))
		else $error("narrow address width drove upper lines or byte line");
	AST_ONE_TAKE: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
		s_ff.done |=> s_ff.st == EMB_IDLE)
		else $error("request taken again in the done cycle");
	AST_CE_SLEEP: assert property (@(posedge clk) disable iff (!rst_b) // [R20]
		$past(sleep_sync_ff) |-> bus_pins.ce_n)
		else $error("chip enable active in sleep");
	AST_BYTE_WRITE: assert property (@(posedge clk) disable iff (!rst_b) // [R24]
		(s_ff.st == EMB_ADR && s_ff.req.tbl_wr && bw16 && wm == 2'b00 && !sleep_sync_ff)
		|=> (bus_pins.write_high_n == !s_ff.req.table_pointer[0]))
		else $error("wrong write strobe for pointer LSB");
	AST_BOTH_HALVES: assert property (@(posedge clk) disable iff (!rst_b) // [R22]
		(s_ff.st == EMB_ACC && s_ff.req.tbl_wr && bw16)
		|-> bus_pins.ad_out[15:8] == bus_pins.ad_out[7:0])
		else $error("table latch not on both halves");
	AST_MCU_NOWRITE: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
		mcu_only |=> $stable(s_ff.bus_control_reg))
		else $error("control register changed in internal-only mode");
	AST_IDLE_PINS: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
		(s_ff.st == EMB_IDLE && !s_ff.busy) |-> (bus_pins.oe_n && bus_pins.write_high_n
		&& bus_pins.write_low_n && !bus_pins.ale && bus_pins.ad_oe == 16'h0000))
		else $error("idle pin levels wrong");
endmodule

// ==== emb_mem_model.sv ====
// Word-wide external memory that answers on the multiplexed bus pins.
// Assumes the pin bundle of emb_pkg and the controller's clock.
`timescale 1ns/1ps
module emb_mem_model (
	input wire logic clk,
	input wire emb_pkg::emb_pins_type bus_pins,
	output logic [15:0] ad_in,
	output logic [20:0] addr_lat,
	output int hi_cnt,
	output int lo_cnt,
	output logic [15:0] wdata
);
	import emb_pkg::*;
	logic [15:0] last;
	logic hi_q;
	logic lo_q;
	initial begin
		last = 16'h0000;
		addr_lat = 21'h000000;
		hi_cnt = 0;
		lo_cnt = 0;
		hi_q = 1'b1;
		lo_q = 1'b1;
	end
	// Released lines show the inverse of the last value, so a stale read cannot match.
	assign ad_in = (!bus_pins.ce_n && !bus_pins.oe_n) ? (addr_lat[16:1] ^ 16'h3c5a) : ~last;
	always @(posedge clk) begin
		last <= ad_in;
		hi_q <= bus_pins.write_high_n;
		lo_q <= bus_pins.write_low_n;
		if (bus_pins.ale) begin
			addr_lat <= {bus_pins.a_hi, bus_pins.ad_out, bus_pins.byte_addr_line};
		end
		if (!bus_pins.write_high_n || !bus_pins.write_low_n) begin
			wdata <= bus_pins.ad_out;
		end
		if (hi_q && !bus_pins.write_high_n && !bus_pins.ce_n) begin
			hi_cnt <= hi_cnt + 1;
		end
		if (lo_q && !bus_pins.write_low_n && !bus_pins.ce_n) begin
			lo_cnt <= lo_cnt + 1;
		end
	end
endmodule

// ==== external_memory_bus_pin_control_test.sv ====
// Self-checking bench of the external bus controller with a memory model on its pins.
// Assumes emb_pkg, emb_ctrl and emb_mem_model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin mismatches++; \
	$display("BAD %s expected %h seen %h", nm, ex, gt); end end
module external_memory_bus_pin_control_test;
	import emb_pkg::*;
	logic clk;
	logic rst_b;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	emb_req_type core_req;
	logic [20:0] program_counter;
	logic sleep_req;
	logic [15:0] ad_in;
	emb_pins_type bus_pins;
	logic [15:0] read_word;
	logic core_done;
	logic core_busy;
	logic pins_are_bus;
	logic [2:0] pu;
	logic [20:0] addr_lat;
	logic [15:0] wdata;
	logic bus_in_acc;
	logic [31:0] q;
	logic e;
	int hi_cnt;
	int lo_cnt;
	int mismatches;
	int checks_done;
	int cycles;
	int c;
	int wc[4];
	emb_ctrl u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core_req(core_req), .program_counter(program_counter), .sleep_req(sleep_req),
		.ad_in(ad_in), .bus_pins(bus_pins), .read_word(read_word), .core_done(core_done),
		.core_busy(core_busy), .pins_are_bus(pins_are_bus), .pullup_ctl_port_d(pu[2]),
		.pullup_ctl_port_e(pu[1]), .pullup_ctl_port_j(pu[0]));
	emb_mem_model u_mem (.clk(clk), .bus_pins(bus_pins), .ad_in(ad_in), .addr_lat(addr_lat),
		.hi_cnt(hi_cnt), .lo_cnt(lo_cnt), .wdata(wdata));
	always #12.5 clk = ~clk;
	// -------------------------------------------------------------------------
	// Watchdog and pin monitor
	// -------------------------------------------------------------------------
	always @(posedge clk) begin
		cycles++;
		if (!bus_pins.ce_n && pins_are_bus) begin
			bus_in_acc <= 1'b1;
		end
		if (cycles == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// -------------------------------------------------------------------------
	// Bus cycles
	// -------------------------------------------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One more edge lets status derived from the new value settle.
		@(posedge clk);
	endtask
	task automatic core(input logic [2:0] op, input logic [20:0] a, input logic ext);
		@(posedge clk);
		core_req <= '{fetch: op[2], tbl_rd: op[1], tbl_wr: op[0], table_pointer: a,
			table_latch: 8'ha7, external: ext};
		program_counter <= a;
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (core_done !== 1'b1 && c < 40);
		core_req <= '0;
	endtask
	// -------------------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------------------
	task automatic t_reset();
		`CHK("pullups", 3'h7, pu)
		apb(0, 12'h004, 0);
		`CHK("port_g", 8'he0, q[7:0])
		apb(0, 12'h010, 0);
		`CHK("unmapped_err", 1'b1, e)
		apb(1, 12'h000, 32'h00000033);
		apb(0, 12'h000, 0);
		`CHK("ctl_ignored", 8'h00, q[7:0])
		`CHK("mcu_ports", 1'b0, pins_are_bus)
	endtask
	task automatic t_fetch();
		apb(1, 12'h008, 32'h0000001c);
		apb(1, 12'h000, 32'h00000030);
		`CHK("bus_owned", 1'b1, pins_are_bus)
		`CHK("idle_ctl", 6'h3f, {bus_pins.ce_n, bus_pins.oe_n, bus_pins.write_high_n,
			bus_pins.write_low_n, bus_pins.upper_byte_sel_n, bus_pins.lower_byte_sel_n})
		`CHK("idle_low", 2'h0, {bus_pins.ale, bus_pins.byte_addr_line})
		`CHK("idle_oe", 20'h00000, {bus_pins.ad_oe, bus_pins.a_hi_oe})
		core(3'b100, 21'h012345, 1'b1);
		`CHK("addr", 21'h012345, addr_lat)
		`CHK("rdata", 16'h91a2 ^ 16'h3c5a, read_word)
		apb(1, 12'h008, 32'h0000001d);
		core(3'b100, 21'h020010, 1'b1);
		`CHK("shift_addr", 21'h000010, addr_lat)
		apb(1, 12'h008, 32'h00000014);
		core(3'b100, 21'h012345, 1'b1);
		`CHK("addr16", 21'h012344, addr_lat)
		apb(1, 12'h008, 32'h00000018);
		core(3'b010, 21'h012345, 1'b1);
		`CHK("rdata8", 16'h00f8, read_word)
	endtask
	task automatic t_wait();
		apb(1, 12'h008, 32'h0000001e);
		for (int f = 3; f >= 0; f--) begin
			apb(1, 12'h000, 32'(f) << 4);
			core(3'b010, 21'h030004, 1'b1);
			wc[f] = c;
			`CHK("wait_len", wc[3] + 3 - f, wc[f])
		end
		apb(1, 12'h008, 32'h0000001c);
		core(3'b010, 21'h030004, 1'b1);
		`CHK("no_wait_len", wc[3], c)
	endtask
	task automatic t_write();
		logic [5:0] tb[7] = '{6'b00_1_1_0_0, 6'b00_0_0_1_0, 6'b01_0_1_0_0, 6'b01_1_1_0_0,
			6'b10_0_1_0_0, 6'b10_1_1_0_0, 6'b11_1_1_0_0};
		int h;
		int l;
		foreach (tb[i]) begin
			apb(1, 12'h000, {28'h0000003, 2'b00, tb[i][5:4]});
			h = hi_cnt;
			l = lo_cnt;
			core(3'b001, {20'h00080, tb[i][3]}, 1'b1);
			`CHK("wr_high", int'(tb[i][2]), hi_cnt - h)
			`CHK("wr_low", int'(tb[i][1]), lo_cnt - l)
			if (tb[i][2] || tb[i][1]) `CHK("wr_data", 16'ha7a7, wdata)
		end
	endtask
	task automatic t_pullup();
		apb(1, 12'h004, 32'h00000000);
		`CHK("pu_on", 3'h0, pu)
		apb(1, 12'h004, 32'h000000a0);
		`CHK("pu_mix", 3'h5, pu)
	endtask
	task automatic t_disable();
		core(3'b100, 21'h000100, 1'b0);
		apb(1, 12'h000, 32'h000000b0);
		`CHK("ports_int", 1'b0, pins_are_bus)
		bus_in_acc <= 1'b0;
		core(3'b100, 21'h040000, 1'b1);
		`CHK("bus_on_ext", 1'b1, bus_in_acc)
		`CHK("deferred", 1'b1, pins_are_bus)
		core(3'b100, 21'h000200, 1'b0);
		`CHK("ports_after", 1'b0, pins_are_bus)
		apb(1, 12'h000, 32'h00000030);
		`CHK("bus_back", 1'b1, pins_are_bus)
	endtask
	task automatic t_sleep();
		sleep_req <= 1'b1;
		repeat (4) @(posedge clk);
		core(3'b100, 21'h012344, 1'b1);
		`CHK("sleep_refused", 40, c)
		`CHK("sleep_pins", 3'h7, {bus_pins.ce_n, bus_pins.upper_byte_sel_n,
			bus_pins.lower_byte_sel_n})
		sleep_req <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		core_req = '0;
		program_counter = 21'h000000;
		sleep_req = 1'b0;
		bus_in_acc = 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_fetch();
		t_wait();
		t_write();
		t_pullup();
		t_disable();
		t_sleep();
		complete_run();
	end
endmodule
